// ==== hw/spe_pkg.sv ====
// spe_pkg: register map, field positions and link state codes of the serial port.
// assumes a 32-bit apb slave with byte addresses in paddr[7:0].
package spe_pkg;
   localparam logic [7:0] ADDR_CTRL   = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h04;
   localparam logic [7:0] ADDR_TXDATA = 8'h08;
   localparam logic [7:0] ADDR_RXDATA = 8'h0c;
   localparam logic [7:0] ADDR_PRIO   = 8'h10;
   // control register fields
   localparam int CTRL_TRANSMIT_ENABLE_BIT  = 0;
   localparam int CTRL_RECEIVE_ENABLE_BIT  = 1;
   localparam int CTRL_SYNC  = 2;
   localparam int CTRL_PEN   = 3;
   localparam int CTRL_PODD  = 4;
   localparam int CTRL_TRANSMIT_TRIGGER_BIT = 5;
   localparam int CTRL_RECEIVE_TRIGGER_BIT = 6;
   // status register fields, write one to clear
   localparam int ST_RXDONE = 0;
   localparam int ST_RXERR  = 1;
   localparam int ST_TXDONE = 2;
   localparam int ST_PERR   = 3;
   localparam int ST_FERR   = 4;
   localparam int ST_OVR    = 5;
   // priority register: serial level [1:0], processor level [3:2]
   localparam int PRIO_SER_LSB = 0;
   localparam int PRIO_CPU_LSB = 2;
   localparam logic [1:0] IRQ_CODE_ERR  = 2'h1;
   localparam logic [1:0] IRQ_CODE_RX   = 2'h2;
   localparam logic [1:0] IRQ_CODE_TX   = 2'h3;
   localparam logic [1:0] PRIO_RESET    = 2'h0;
   // link clock ticks per bit: async oversamples by 8, sync uses a /2 shift clock
   localparam logic [2:0] TICK_LAST_ASYNC = 3'h7;
   localparam logic [2:0] TICK_LAST_SYNC  = 3'h1;
   localparam logic [2:0] TICK_MID_START  = 3'h3;
   localparam logic [2:0] BIT_LAST        = 3'h7;
   typedef enum logic [2:0] {
      SPE_IDLE  = 3'b000,
      SPE_HUNT  = 3'b001,
      SPE_START = 3'b010,
      SPE_DATA  = 3'b011,
      SPE_PAR   = 3'b100,
      SPE_STOP  = 3'b101
   } spe_state_e;
   function automatic logic spe_hit(input logic [7:0] addr, input logic [7:0] off);
      spe_hit = (addr == off);
   endfunction
endpackage

// ==== hw/spe_link_if.sv ====
// spe_link_if: signals between the register core and the link-clock shift engine.
// assumes toggles cross by two-flop sync; data words stay frozen while a toggle is in flight.
`timescale 1ns/1ns
`default_nettype none
interface spe_link_if;
   logic       tx_req_tgl;
   logic       rx_req_tgl;
   logic       mode_sync;
   logic       par_en;
   logic       par_odd;
   logic [7:0] tx_byte;
   logic       tx_ack_tgl;
   logic       rx_ack_tgl;
   logic [7:0] rx_byte;
   logic       rx_perr;
   logic       rx_ferr;
   modport core (output tx_req_tgl, rx_req_tgl, mode_sync, par_en, par_odd, tx_byte,
                 input tx_ack_tgl, rx_ack_tgl, rx_byte, rx_perr, rx_ferr);
   modport link (input tx_req_tgl, rx_req_tgl, mode_sync, par_en, par_odd, tx_byte,
                 output tx_ack_tgl, rx_ack_tgl, rx_byte, rx_perr, rx_ferr);
endinterface
`default_nettype wire

// ==== hw/spe_link_engine.sv ====
// spe_link_engine: transmit and receive shifters on the link clock.
// assumes config and tx byte are stable from a request toggle until its ack toggle.
`timescale 1ns/1ns
`default_nettype none
module spe_link_engine
   import spe_pkg::*;
(
   // link clock and raw reset
   input  wire logic link_clk,
   input  wire logic rst_n,
   // serial pins
   input  wire logic rxd,
   output logic      txd,
   output logic      sclk,
   // core side
   spe_link_if.link  lk
);
   typedef struct packed {
      logic       rs0, rs1, d0, d1;
      logic [2:0] ts, rs;
      spe_state_e tst, rst;
      logic [2:0] tt, rt, tc, rc;
      logic [7:0] tsh, rsh;
      logic       rpar, perr, ferr, tack, rack, txd, sclk;
   } spe_link_s;
   spe_link_s q, next_q;
   logic [2:0] last;

   always_comb begin
      next_q = q;
      last = lk.mode_sync ? TICK_LAST_SYNC : TICK_LAST_ASYNC;
      // reset and rxd pass two flops before use
      next_q.rs0 = rst_n;
      next_q.rs1 = q.rs0;
      next_q.d0  = rxd;
      next_q.d1  = q.d0;
      next_q.ts  = {q.ts[1:0], lk.tx_req_tgl};
      next_q.rs  = {q.rs[1:0], lk.rx_req_tgl};
      next_q.tt  = (q.tst == SPE_IDLE || q.tt == last) ? 3'h0 : q.tt + 3'h1;
      next_q.rt  = (q.rst == SPE_IDLE || q.rst == SPE_HUNT || q.rt == last) ? 3'h0 : q.rt + 3'h1;
      case (q.tst)
         SPE_IDLE: begin
            next_q.txd = 1'b1;
            if (q.ts[2] ^ q.ts[1]) begin
               next_q.tsh = lk.tx_byte;
               next_q.tc  = 3'h0;
               next_q.tst = lk.mode_sync ? SPE_DATA : SPE_START;
               next_q.txd = lk.mode_sync ? lk.tx_byte[0] : 1'b0;
            end
         end
         SPE_START: if (q.tt == last) begin
            next_q.tst = SPE_DATA;
            next_q.txd = q.tsh[0];
         end
         SPE_DATA: if (q.tt == last) begin
            if (q.tc == BIT_LAST) begin
               if (lk.mode_sync) begin
                  next_q.tst  = SPE_IDLE;
                  next_q.tack = ~q.tack;
                  next_q.txd  = 1'b1;
               end else begin
                  next_q.tst = lk.par_en ? SPE_PAR : SPE_STOP;
                  next_q.txd = lk.par_en ? ((^lk.tx_byte) ^ lk.par_odd) : 1'b1;
               end
            end else begin
               next_q.tc  = q.tc + 3'h1;
               next_q.tsh = {1'b0, q.tsh[7:1]};
               next_q.txd = q.tsh[1];
            end
         end
         SPE_PAR: if (q.tt == last) begin
            next_q.tst = SPE_STOP;
            next_q.txd = 1'b1;
         end
         SPE_STOP: if (q.tt == last) begin
            next_q.tst  = SPE_IDLE;
            next_q.tack = ~q.tack;
         end
         default: next_q.tst = SPE_IDLE;
      endcase
      case (q.rst)
         SPE_IDLE: if (q.rs[2] ^ q.rs[1]) begin
            next_q.rc   = 3'h0;
            next_q.rpar = 1'b0;
            next_q.perr = 1'b0;
            next_q.ferr = 1'b0;
            next_q.rst  = lk.mode_sync ? SPE_DATA : SPE_HUNT;
         end
         SPE_HUNT: if (!q.d1) next_q.rst = SPE_START;
         SPE_START: if (q.rt == TICK_MID_START) begin
            // realign so later bits are sampled mid-bit at the last tick
            next_q.rt  = 3'h0;
            next_q.rst = q.d1 ? SPE_HUNT : SPE_DATA;
         end
         SPE_DATA: if (q.rt == last) begin
            next_q.rsh  = {q.d1, q.rsh[7:1]};
            next_q.rpar = q.rpar ^ q.d1;
            next_q.rc   = q.rc + 3'h1;
            if (q.rc == BIT_LAST) begin
               if (lk.mode_sync) begin
                  next_q.rst  = SPE_IDLE;
                  next_q.rack = ~q.rack;
               end else begin
                  next_q.rst = lk.par_en ? SPE_PAR : SPE_STOP;
               end
            end
         end
         SPE_PAR: if (q.rt == last) begin
            next_q.perr = (q.rpar ^ q.d1) != lk.par_odd;
            next_q.rst  = SPE_STOP;
         end
         SPE_STOP: if (q.rt == last) begin
            next_q.ferr = ~q.d1;
            next_q.rst  = SPE_IDLE;
            next_q.rack = ~q.rack;
         end
         default: next_q.rst = SPE_IDLE;
      endcase
      // one shift clock line, idle high, low in the first half of each bit; half-duplex
      if (lk.mode_sync && next_q.tst != SPE_IDLE) begin
         next_q.sclk = next_q.tt[0];
      end else if (lk.mode_sync && next_q.rst != SPE_IDLE) begin
         next_q.sclk = next_q.rt[0];
      end else begin
         next_q.sclk = 1'b1;
      end
      if (!q.rs1) begin
         next_q      = '0;
         next_q.rs0  = rst_n;
         next_q.rs1  = q.rs0;
         next_q.txd  = 1'b1;
         next_q.sclk = 1'b1;
         next_q.tst  = SPE_IDLE;
         next_q.rst  = SPE_IDLE;
      end
   end

   always_ff @(posedge link_clk) begin
      q <= next_q;
   end

   assign txd           = q.txd;
   assign sclk          = q.sclk;
   assign lk.tx_ack_tgl = q.tack;
   assign lk.rx_ack_tgl = q.rack;
   assign lk.rx_byte    = q.rsh;
   assign lk.rx_perr    = q.perr;
   assign lk.rx_ferr    = q.ferr;
endmodule // spe_link_engine
`default_nettype wire

// ==== hw/spe_serial_port.sv ====
// spe_serial_port: apb register core of the serial port with error/receive flags
// and a prioritised interrupt request; shifters run in the link clock domain.
// assumes clk and link_clk are unrelated; rst_n held long enough to reach both domains.
`timescale 1ns/1ns
`default_nettype none
module spe_serial_port
   import spe_pkg::*;
(
   // system clock and reset
   input  wire logic        clk,
   input  wire logic        rst_n,
   // link clock
   input  wire logic        link_clk,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic             pready,
   output logic [31:0]      prdata,
   output logic             pslverr,
   // serial pins
   input  wire logic        rxd,
   output logic             txd,
   output logic             sclk,
   // interrupt request to the priority logic
   output logic             irq_req,
   output logic [1:0]       irq_code
);
   typedef struct packed {
      logic        pready;
      logic [31:0] prdata;
      logic        pslverr;
      logic        transmit_enable_bit;
      logic        receive_enable_bit;
      logic        sync;
      logic        pen;
      logic        podd;
      logic        transmit_trigger_bit;
      logic        receive_trigger_bit;
      logic [7:0]  txbyte;
      logic [7:0]  rxbyte;
      logic        rx_done_flag;
      logic        rx_error_flag;
      logic        tx_done_flag;
      logic        perr;
      logic        ferr;
      logic        ovr;
      logic [1:0]  ser_level;
      logic [1:0]  cpu_level;
      logic        txreq;
      logic        rxreq;
      logic [2:0]  tas;
      logic [2:0]  ras;
      logic        irq_req;
      logic [1:0]  irq_code;
   } spe_core_s;

   spe_core_s  q;
   spe_core_s  next_q;
   spe_link_if lk ();

   logic        access;
   logic        wr;
   logic        tx_ev;
   logic        rx_ev;
   logic        rx_bad;
   logic [31:0] rd_word;
   logic        mapped;
   logic        pending;

   spe_link_engine u_link (
      .link_clk (link_clk),
      .rst_n    (rst_n),
      .rxd      (rxd),
      .txd      (txd),
      .sclk     (sclk),
      .lk       (lk.link)
   );

   always_comb begin
      next_q  = q;
      access  = psel && penable && !q.pready;
      wr      = access && pwrite;
      rd_word = 32'h0000_0000;
      mapped  = 1'b1;

      // ack toggles cross by two flops; third flop remembers the last seen level
      next_q.tas = {q.tas[1:0], lk.tx_ack_tgl};
      next_q.ras = {q.ras[1:0], lk.rx_ack_tgl};
      tx_ev      = q.tas[2] ^ q.tas[1];
      rx_ev      = q.ras[2] ^ q.ras[1];
      rx_bad     = lk.rx_perr || lk.rx_ferr;

      // read mux
      if (spe_hit(paddr, ADDR_CTRL)) begin
         rd_word[CTRL_TRANSMIT_ENABLE_BIT]  = q.transmit_enable_bit;
         rd_word[CTRL_RECEIVE_ENABLE_BIT]  = q.receive_enable_bit;
         rd_word[CTRL_SYNC]  = q.sync;
         rd_word[CTRL_PEN]   = q.pen;
         rd_word[CTRL_PODD]  = q.podd;
         rd_word[CTRL_TRANSMIT_TRIGGER_BIT] = q.transmit_trigger_bit;
         rd_word[CTRL_RECEIVE_TRIGGER_BIT] = q.receive_trigger_bit;
      end else if (spe_hit(paddr, ADDR_STATUS)) begin
         rd_word[ST_RXDONE] = q.rx_done_flag;
         rd_word[ST_RXERR]  = q.rx_error_flag;
         rd_word[ST_TXDONE] = q.tx_done_flag;
         rd_word[ST_PERR]   = q.perr;
         rd_word[ST_FERR]   = q.ferr;
         rd_word[ST_OVR]    = q.ovr;
      end else if (spe_hit(paddr, ADDR_TXDATA)) begin
         rd_word[7:0] = q.txbyte;
      end else if (spe_hit(paddr, ADDR_RXDATA)) begin
         rd_word[7:0] = q.rxbyte;
      end else if (spe_hit(paddr, ADDR_PRIO)) begin
         rd_word[PRIO_SER_LSB +: 2] = q.ser_level;
         rd_word[PRIO_CPU_LSB +: 2] = q.cpu_level;
      end else begin
         mapped = 1'b0;
      end

      // apb answer: one wait state, registered ready, data and error
      next_q.pready  = access;
      next_q.pslverr = access && !mapped;
      next_q.prdata  = (access && !pwrite) ? rd_word : 32'h0000_0000;

      // software clears come first so a same-cycle hardware set wins below
      if (wr && spe_hit(paddr, ADDR_STATUS)) begin
         if (pwdata[ST_RXDONE]) next_q.rx_done_flag  = 1'b0;
         if (pwdata[ST_RXERR])  next_q.rx_error_flag = 1'b0;
         if (pwdata[ST_TXDONE]) next_q.tx_done_flag  = 1'b0;
         if (pwdata[ST_PERR])   next_q.perr          = 1'b0;
         if (pwdata[ST_FERR])   next_q.ferr          = 1'b0;
         if (pwdata[ST_OVR])    next_q.ovr           = 1'b0;
      end

      if (wr && spe_hit(paddr, ADDR_CTRL)) begin
         next_q.transmit_enable_bit = pwdata[CTRL_TRANSMIT_ENABLE_BIT];
         next_q.receive_enable_bit = pwdata[CTRL_RECEIVE_ENABLE_BIT];
         // mode bits feed the link unsynchronised, so they only move while both enables and both triggers are clear
         if (!q.transmit_enable_bit && !q.receive_enable_bit && !q.transmit_trigger_bit && !q.receive_trigger_bit) begin
            next_q.sync = pwdata[CTRL_SYNC];
            next_q.pen  = pwdata[CTRL_PEN];
            next_q.podd = pwdata[CTRL_PODD];
         end
         // a retrigger while busy is ignored; in sync mode the other direction blocks
         if (pwdata[CTRL_TRANSMIT_TRIGGER_BIT] && pwdata[CTRL_TRANSMIT_ENABLE_BIT] && !q.transmit_trigger_bit
             && !(q.sync && q.receive_trigger_bit)) begin
            next_q.transmit_trigger_bit = 1'b1;
            next_q.txreq = ~q.txreq;
         end
         if (pwdata[CTRL_RECEIVE_TRIGGER_BIT] && pwdata[CTRL_RECEIVE_ENABLE_BIT] && !q.receive_trigger_bit
             && !(q.sync && (q.transmit_trigger_bit || pwdata[CTRL_TRANSMIT_TRIGGER_BIT]))) begin
            next_q.receive_trigger_bit = 1'b1;
            next_q.rxreq = ~q.rxreq;
         end
      end

      // transmit byte is read by the link domain, so it is frozen while sending
      if (wr && spe_hit(paddr, ADDR_TXDATA) && !q.transmit_trigger_bit) begin
         next_q.txbyte = pwdata[7:0];
      end

      if (wr && spe_hit(paddr, ADDR_PRIO)) begin
         next_q.ser_level = pwdata[PRIO_SER_LSB +: 2];
         next_q.cpu_level = pwdata[PRIO_CPU_LSB +: 2];
      end

      // transfer completion from the link domain
      if (tx_ev) begin
         next_q.transmit_trigger_bit        = 1'b0;
         next_q.tx_done_flag = 1'b1;
      end
      if (rx_ev) begin
         next_q.receive_trigger_bit = 1'b0;
         if (q.rx_done_flag) begin
            // previous byte unread: keep it, flag error only
            next_q.rx_error_flag = 1'b1;
            next_q.ovr           = 1'b1;
         end else begin
            next_q.rxbyte       = lk.rx_byte;
            next_q.rx_done_flag = 1'b1;
            if (rx_bad) begin
               next_q.rx_error_flag = 1'b1;
               next_q.perr          = lk.rx_perr;
               next_q.ferr          = lk.rx_ferr;
            end
         end
      end

      // level requests: a flag left set, or a lowered processor level, asks again
      pending = q.rx_error_flag || q.rx_done_flag || q.tx_done_flag;
      next_q.irq_req = pending && (q.ser_level > q.cpu_level);
      // the source code is only shown while a request is raised
      if (!next_q.irq_req) begin
         next_q.irq_code = 2'h0;
      end else if (q.rx_error_flag) begin
         next_q.irq_code = IRQ_CODE_ERR;
      end else if (q.rx_done_flag) begin
         next_q.irq_code = IRQ_CODE_RX;
      end else if (q.tx_done_flag) begin
         next_q.irq_code = IRQ_CODE_TX;
      end else begin
         next_q.irq_code = 2'h0;
      end

      if (!rst_n) begin
         next_q           = '0;
         next_q.ser_level = PRIO_RESET;
         next_q.cpu_level = PRIO_RESET;
      end
   end

   always_ff @(posedge clk) begin
      q <= next_q;
   end

   assign lk.tx_req_tgl = q.txreq;
   assign lk.rx_req_tgl = q.rxreq;
   assign lk.mode_sync  = q.sync;
   assign lk.par_en     = q.pen;
   assign lk.par_odd    = q.podd;
   assign lk.tx_byte    = q.txbyte;

   assign pready   = q.pready;
   assign prdata   = q.prdata;
   assign pslverr  = q.pslverr;
   assign irq_req  = q.irq_req;
   assign irq_code = q.irq_code;
endmodule // spe_serial_port
`default_nettype wire

// ==== bench/spe_serial_port_properties.sv ====
// spe_serial_port_properties: port-level checks of the serial port core.
// assumes an apb master that holds each request until pready.
`timescale 1ns/1ns
`default_nettype none
module spe_serial_port_properties
   import spe_pkg::*;
(
   // clocks and reset
   input wire logic        clk,
   input wire logic        rst_n,
   input wire logic        link_clk,
   // apb
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic        pready,
   input wire logic [31:0] prdata,
   input wire logic        pslverr,
   // pin and request
   input wire logic        sclk,
   input wire logic        irq_req,
   input wire logic [1:0]  irq_code
);
   sequence s_take;
      psel && penable && !pready;
   endsequence
   sequence s_mask;
      s_take ##0 (pwrite && paddr == ADDR_PRIO && pwdata[3:2] >= pwdata[1:0]);
   endsequence
   property p_ready_one;
      @(posedge clk) disable iff (!rst_n) s_take |=> pready ##1 !pready;
   endproperty
   a_ready_one: assert property (p_ready_one) else $error("apb answer not one cycle");
   property p_unmapped;
      @(posedge clk) disable iff (!rst_n) pready && paddr > ADDR_PRIO |-> pslverr && prdata == 0;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
   property p_idle_bus;
      @(posedge clk) disable iff (!rst_n) !pready |-> prdata == 32'h0000_0000 && !pslverr;
   endproperty
   a_idle_bus: assert property (p_idle_bus) else $error("read data outside answer");
   property p_code_match;
      @(posedge clk) disable iff (!rst_n) irq_req != (irq_code == 2'h0);
   endproperty
   a_code_match: assert property (p_code_match) else $error("request and source disagree");
   property p_mask;
      @(posedge clk) disable iff (!rst_n) s_mask |-> ##2 !irq_req;
   endproperty
   a_mask: assert property (p_mask) else $error("request not masked by level");
   // error source may only give way after software writes something
   property p_err_first;
      @(posedge clk) disable iff (!rst_n)
         irq_code == IRQ_CODE_ERR && !(psel && penable && pwrite) |=> irq_code == IRQ_CODE_ERR;
   endproperty
   a_err_first: assert property (p_err_first) else $error("error request overtaken");
   property p_sclk_low;
      @(posedge link_clk) disable iff (!rst_n) $fell(sclk) |=> sclk;
   endproperty
   a_sclk_low: assert property (p_sclk_low) else $error("shift clock low too long");
   property p_reset;
      @(posedge clk) !rst_n |=> !pready && !irq_req;
   endproperty
   a_reset: assert property (p_reset) else $error("outputs active in reset");
endmodule // spe_serial_port_properties
bind spe_serial_port spe_serial_port_properties chk_u (.clk, .rst_n, .link_clk, .psel,
   .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr, .sclk, .irq_req, .irq_code);
`default_nettype wire

// ==== bench/spe_peer_model.sv ====
// spe_peer_model: external serial peer, sends and captures frames.
// assumes 8 link clocks per async bit, even parity, lsb first.
`timescale 1ns/1ns
`default_nettype none
module spe_peer_model (
   // link clock and pins
   input  wire logic link_clk,
   input  wire logic txd,
   input  wire logic sclk,
   output logic      rxd
);
   // idle line is high between frames
   initial rxd = 1'b1;
   task automatic bit_out(input logic v);
      rxd <= v;
      repeat (8) @(posedge link_clk);
   endtask
   task automatic send(input logic [7:0] b, input logic badp, input logic bads);
      @(posedge link_clk);
      bit_out(1'b0);
      for (int i = 0; i < 8; i++) bit_out(b[i]);
      bit_out(^b ^ badp);
      bit_out(!bads);
      bit_out(1'b1);
   endtask
   task automatic cap_async(output logic [7:0] b, output logic p, output logic s);
      @(negedge txd);
      repeat (4) @(posedge link_clk);
      for (int i = 0; i < 8; i++) begin
         repeat (8) @(posedge link_clk);
         b[i] = txd;
      end
      repeat (8) @(posedge link_clk);
      p = txd;
      repeat (8) @(posedge link_clk);
      s = txd;
   endtask
   task automatic cap_sync(output logic [7:0] b);
      for (int i = 0; i < 8; i++) begin
         @(posedge sclk);
         b[i] = txd;
      end
   endtask
endmodule // spe_peer_model
`default_nettype wire

// ==== bench/testbench.sv ====
// testbench: drives the serial port over apb against a serial peer model.
// assumes 50 ns system clock and an unrelated 64 ns link clock.
`timescale 1ns/1ns
`default_nettype none
module testbench
   import spe_pkg::*;
;
   logic        clk = 1'b0;
   logic        link_clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic        pready, pslverr, rxd, txd, sclk, irq_req, lerr, cp, cs;
   logic [31:0] prdata, rdv;
   logic [1:0]  irq_code;
   logic [7:0]  cb;
   int          err_count = 0;
   int          total_checks = 0;
   spe_serial_port dut_u (.clk(clk), .rst_n(rst_n), .link_clk(link_clk), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
      .prdata(prdata), .pslverr(pslverr), .rxd(rxd), .txd(txd), .sclk(sclk),
      .irq_req(irq_req), .irq_code(irq_code));
   spe_peer_model peer_u (.link_clk(link_clk), .txd(txd), .sclk(sclk), .rxd(rxd));
   initial forever #25 clk = ~clk;
   initial begin
      #7;
      forever #32 link_clk = ~link_clk;
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rdv = prdata;
      lerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0000_0000);
      chk(rdv, exp);
   endtask
   task automatic irq(input logic r, input logic [1:0] c);
      repeat (2) @(posedge clk);
      chk({29'h0, irq_req, irq_code}, {29'h0, r, c});
   endtask
   // polls until the trigger bit drops; a stuck trigger counts as a mismatch
   task automatic poll(input int b);
      int n;
      n = 0;
      do apb(1'b0, ADDR_CTRL, 32'h0000_0000); while (rdv[b] !== 1'b0 && ++n < 300);
      if (n >= 300) err_count++;
   endtask
   task automatic rx(input logic [7:0] b, input logic badp, input logic bads);
      wr(ADDR_CTRL, 32'h0000_004a);
      repeat (10) @(posedge clk);
      peer_u.send(b, badp, bads);
      poll(CTRL_RECEIVE_TRIGGER_BIT);
   endtask
   task automatic t_reset;
      rd(ADDR_CTRL, 32'h0000_0000);
      rd(ADDR_STATUS, 32'h0000_0000);
      rd(ADDR_PRIO, 32'h0000_0000);
      rd(8'h14, 32'h0000_0000);
      chk({31'h0, lerr}, 32'h0000_0001);
      $display("done t_reset");
   endtask
   task automatic t_rx_good;
      wr(ADDR_PRIO, 32'h0000_0002);
      wr(ADDR_CTRL, 32'h0000_004a);
      rd(ADDR_CTRL, 32'h0000_004a);
      peer_u.send(8'ha5, 1'b0, 1'b0);
      poll(CTRL_RECEIVE_TRIGGER_BIT);
      rd(ADDR_STATUS, 32'h0000_0001);
      rd(ADDR_RXDATA, 32'h0000_00a5);
      irq(1'b1, IRQ_CODE_RX);
      wr(ADDR_STATUS, 32'h0000_0001);
      irq(1'b0, 2'h0);
      $display("done t_rx_good");
   endtask
   task automatic t_rx_parity;
      rx(8'h3c, 1'b1, 1'b0);
      rd(ADDR_STATUS, 32'h0000_000b);
      irq(1'b1, IRQ_CODE_ERR);
      wr(ADDR_PRIO, 32'h0000_000e);
      irq(1'b0, 2'h0);
      wr(ADDR_PRIO, 32'h0000_0002);
      irq(1'b1, IRQ_CODE_ERR);
      wr(ADDR_STATUS, 32'h0000_000a);
      irq(1'b1, IRQ_CODE_RX);
      wr(ADDR_STATUS, 32'h0000_0001);
      irq(1'b0, 2'h0);
      $display("done t_rx_parity");
   endtask
   task automatic t_rx_frame;
      // odd parity: the peer's inverted parity bit is then the correct one
      wr(ADDR_CTRL, 32'h0000_0008);
      wr(ADDR_CTRL, 32'h0000_005a);
      repeat (10) @(posedge clk);
      peer_u.send(8'h81, 1'b1, 1'b1);
      poll(CTRL_RECEIVE_TRIGGER_BIT);
      rd(ADDR_STATUS, 32'h0000_0013);
      rd(ADDR_RXDATA, 32'h0000_0081);
      wr(ADDR_STATUS, 32'h0000_0013);
      wr(ADDR_CTRL, 32'h0000_0018);
      $display("done t_rx_frame");
   endtask
   task automatic t_overrun;
      rx(8'h11, 1'b0, 1'b0);
      rd(ADDR_STATUS, 32'h0000_0001);
      rx(8'h22, 1'b0, 1'b0);
      rd(ADDR_STATUS, 32'h0000_0023);
      rd(ADDR_RXDATA, 32'h0000_0011);
      irq(1'b1, IRQ_CODE_ERR);
      wr(ADDR_STATUS, 32'h0000_003f);
      irq(1'b0, 2'h0);
      $display("done t_overrun");
   endtask
   task automatic t_tx_async;
      wr(ADDR_TXDATA, 32'h0000_005a);
      fork
         peer_u.cap_async(cb, cp, cs);
         wr(ADDR_CTRL, 32'h0000_0029);
      join
      chk({24'h0, cb}, 32'h0000_005a);
      chk({30'h0, cp, cs}, 32'h0000_0001);
      poll(CTRL_TRANSMIT_TRIGGER_BIT);
      rd(ADDR_STATUS, 32'h0000_0004);
      irq(1'b1, IRQ_CODE_TX);
      wr(ADDR_STATUS, 32'h0000_0004);
      irq(1'b0, 2'h0);
      $display("done t_tx_async");
   endtask
   task automatic t_sync;
      wr(ADDR_CTRL, 32'h0000_0008);
      wr(ADDR_CTRL, 32'h0000_0004);
      wr(ADDR_TXDATA, 32'h0000_00c3);
      wr(ADDR_CTRL, 32'h0000_0007);
      fork
         peer_u.cap_sync(cb);
         begin
            wr(ADDR_CTRL, 32'h0000_0027);
            wr(ADDR_CTRL, 32'h0000_0047);
            rd(ADDR_CTRL, 32'h0000_0027);
         end
      join
      chk({24'h0, cb}, 32'h0000_00c3);
      poll(CTRL_TRANSMIT_TRIGGER_BIT);
      rd(ADDR_STATUS, 32'h0000_0004);
      wr(ADDR_STATUS, 32'h0000_0004);
      wr(ADDR_CTRL, 32'h0000_0004);
      rd(ADDR_CTRL, 32'h0000_0004);
      $display("done t_sync");
   endtask
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // hang guard, well above the several hundred cycles the frames take
   initial begin
      repeat (40000) @(posedge clk);
      err_count++;
      report_and_stop;
   end
   initial begin
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      repeat (8) @(posedge clk);
      t_reset;
      t_rx_good;
      t_rx_parity;
      t_rx_frame;
      t_overrun;
      t_tx_async;
      t_sync;
      report_and_stop;
   end
endmodule // testbench
`default_nettype wire
